/* isl_cfg.svh */
`ifndef ISL_CFG_SVH
`define ISL_CFG_SVH

// register offsets
`define ISL_ADDR_GIE 8'h20
`define ISL_ADDR_EP_EN 8'h21
`define ISL_ADDR_PSC 8'h30
`define ISL_ADDR_DAC_EN 8'h31
`define ISL_ADDR_DAC_POL 8'h32
`define ISL_ADDR_GPIO_CFG 8'h33
`define ISL_ADDR_GPIO_EN0 8'h34
`define ISL_ADDR_I2C_SC 8'h38
`define ISL_ADDR_PEND_LO 8'h39
`define ISL_ADDR_PEND_HI 8'h3A
`define ISL_ADDR_HUB_EN 8'h49
`define ISL_ADDR_HUB_FORCE 8'h51

// field positions
`define ISL_PSC_BRST_BIT 5
`define ISL_PSC_SENSE_BIT 7
`define ISL_GPIO_PARALLEL_ASSIST_PORT_BIT 7
`define ISL_I2C_MASTER_BIT 3

// pending bit of each vector (vector number minus one)
`define ISL_V_BRST 0
`define ISL_V_T128 1
`define ISL_V_T1MS 2
`define ISL_V_EP0 3
`define ISL_V_HUB 8
`define ISL_V_DAC 9
`define ISL_V_GPIO 10
`define ISL_V_I2C 11
`define ISL_NVEC 12

// timing
`define ISL_CLK_MHZ 125
`define ISL_T128_US 128
`define ISL_T1MS_US 1024
`define ISL_BRST_MIN_US 12
`define ISL_T128_CYC (`ISL_T128_US * `ISL_CLK_MHZ)
`define ISL_T1MS_CYC (`ISL_T1MS_US * `ISL_CLK_MHZ)
`define ISL_BRST_CYC (`ISL_BRST_MIN_US * `ISL_CLK_MHZ)
`define ISL_CALL_CYC 10
`define ISL_JMP_CYC 5
`define ISL_ENTRY_CYC (`ISL_CALL_CYC + `ISL_JMP_CYC)

`endif

/* isl_pkg.sv */
package isl_pkg;

  typedef enum logic {ISL_IDLE, ISL_ENTRY} isl_seq_t;

  typedef struct packed {
    logic [3:0] conn_chg;
    logic [3:0] babble;
    logic [3:0] resume;
  } isl_hub_ev_t;

  typedef struct packed {
    logic byte_done;
    logic start;
    logic stop;
    logic arb_lost;
    logic ack_in;
  } isl_i2c_ev_t;

  typedef struct packed {
    logic proceed;
    logic arb_lost;
    logic stop_seen;
    logic master;
    logic xmit;
    logic addr;
    logic ack;
  } isl_i2c_ctl_t;

  typedef struct packed {
    isl_seq_t st;
    logic [3:0] ent_cnt;
    logic [3:0] vec;
    logic isr_start;
    logic irq;
    logic [11:0] pend;
    logic [6:0] gie;
    logic [4:0] ep_en;
    logic [3:0] hub_en;
    logic [7:0] force_dn;
    logic psc_brst;
    logic [7:0] dac_en;
    logic [7:0] dac_pol;
    logic [7:0] gpio_cfg;
    logic [31:0] gpio_en;
    isl_i2c_ctl_t i2c;
    logic i2c_first;
    logic arb_wait;
    logic stop_req;
    logic [10:0] se0_cnt;
    logic brst_det;
    logic brst_clr;
    logic por_abort;
    logic [16:0] t128;
    logic [16:0] t1ms;
    logic [7:0] rdata;
  } isl_state_t;

endpackage : isl_pkg

/* isl_edge_lock.sv */
`timescale 1ns/10ps
module isl_edge_lock import isl_pkg::*; #(
  parameter int N = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] pin_i,
  input wire logic [N-1:0] en_i,
  input wire logic [N-1:0] pol_i,
  input wire logic block_i,
  output logic trig_o
);

  typedef struct packed {
    logic [N-1:0] prev;
    logic [N-1:0] lock;
    logic trig;
  } isl_lock_st_t;

  isl_lock_st_t s_ff;
  isl_lock_st_t nxt_s;
  logic [N-1:0] act;
  logic [N-1:0] held;
  logic [N-1:0] edge_hit;

  // active level: high for positive polarity, low for negative
  assign act = ~(pin_i ^ pol_i);
  assign held = s_ff.lock & act & en_i;
  assign edge_hit = act & ~s_ff.prev & en_i;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.prev = act;
    nxt_s.lock = held;
    nxt_s.trig = 1'b0;
    if (held == '0 && edge_hit != '0 && !block_i) begin
      nxt_s.trig = 1'b1;
      nxt_s.lock = edge_hit;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign trig_o = s_ff.trig;

  AST_LOCKOUT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (held != '0) |=> !trig_o)
    else $error("edge fired while another pin held the lock");

endmodule : isl_edge_lock

/* isl_top.sv */
// Summary of operation
// - entry waits instruction end, then 10 call and 5 jump cycles
// - bus reset when both upstream lines low at least 12 us
// - bus reset sets status bit 5 for firmware
// - bus reset clears address and hub port registers
// - bus reset irq when lines leave all-low; aborts start-up delay
// - periodic timer interrupts every 128 us and 1.024 ms
// - each endpoint interrupts on final handshake of a transaction
// - hub irq on connect change, or enabled babble or resume
// - connect changes on forced ports raise no hub irq
// - enabled DAC pins raise shared irq on selected edge
// - triggered DAC pin locks others out until inactive or disabled
// - enabled GPIO pins raise shared irq, polarity per port
// - triggered GPIO pin locks others out until inactive or disabled
// - enabled parallel assist port owns GPIO vector, gated by config bit 7
// - slave receive irq each byte; address flag on first byte
// - slave receive stop sets flag and irq unless ack was 0
// - slave transmit irq each byte; ack bit reports master ack
// - master modes irq each byte; clearing master bit sends stop
// - lost arbitration clears master bit, sets flag, irq at stop
// - proceed flag cleared before byte-complete interrupts, except in master receive
// - each source latches pending until serviced; enable gates request
// - lowest pending enabled vector wins; bus reset first, I2C last
`timescale 1ns/10ps
`include "isl_cfg.svh"
module isl_top import isl_pkg::*; #(
  parameter logic [16:0] T128_CYC = 17'(`ISL_T128_CYC),
  parameter logic [16:0] T1MS_CYC = 17'(`ISL_T1MS_CYC)
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic por_delay_i,
  input wire logic [4:0] ep_in_ack_i,
  input wire logic [4:0] ep_out_ack_i,
  input wire isl_hub_ev_t hub_ev_i,
  input wire logic [7:0] dac_pin_i,
  input wire logic [31:0] gpio_pin_i,
  input wire logic parallel_assist_port_ev_i,
  input wire isl_i2c_ev_t i2c_ev_i,
  input wire logic cpu_instr_end_i,
  input wire logic cpu_gie_i,
  output logic isr_start_o,
  output logic [3:0] vector_o,
  output logic irq_o,
  output logic brst_clr_o,
  output logic por_abort_o,
  output logic [3:0] hub_port_en_o,
  output logic [7:0] hub_force_o,
  output isl_i2c_ctl_t i2c_ctl_o,
  output logic i2c_stop_req_o
);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  isl_state_t s_ff;
  isl_state_t nxt_s;
  logic [3:0] forced;
  logic hub_raw;
  logic dac_trig;
  logic gpio_trig;
  logic [31:0] gpio_pol;
  logic [11:0] req;
  logic se0;
  logic parallel_assist_port_on;

  function automatic logic [11:0] isl_en_vec(input logic [6:0] gie,
                                             input logic [4:0] ep_en);
    isl_en_vec = {gie[6:3], ep_en, gie[2:0]};
  endfunction : isl_en_vec

  // index of lowest set bit, lowest vector has priority
  function automatic logic [3:0] isl_lowest(input logic [11:0] r);
    isl_lowest = 4'h0;
    for (int i = `ISL_NVEC - 1; i >= 0; i--) begin
      if (r[i]) begin
        isl_lowest = 4'(i);
      end
    end
  endfunction : isl_lowest

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      assign forced[g] = |s_ff.force_dn[2*g+1:2*g];
      assign gpio_pol[8*g+7:8*g] = {8{s_ff.gpio_cfg[g]}};
    end
  endgenerate

  assign hub_raw = |(hub_ev_i.conn_chg & ~forced)
    | |((hub_ev_i.babble | hub_ev_i.resume) & s_ff.hub_en);
  assign parallel_assist_port_on = s_ff.gpio_cfg[`ISL_GPIO_PARALLEL_ASSIST_PORT_BIT];
  assign se0 = !dp_i && !dm_i;
  assign req = s_ff.pend & isl_en_vec(s_ff.gie, s_ff.ep_en);

  isl_edge_lock #(.N(8)) u_dac (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(dac_pin_i),
    .en_i(s_ff.dac_en),
    .pol_i(s_ff.dac_pol),
    .block_i(1'b0),
    .trig_o(dac_trig)
  );

  isl_edge_lock #(.N(32)) u_gpio (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(gpio_pin_i),
    .en_i(s_ff.gpio_en),
    .pol_i(gpio_pol),
    .block_i(parallel_assist_port_on),
    .trig_o(gpio_trig)
  );

  always_comb begin
    logic [11:0] set;
    logic [11:0] clr;
    logic [3:0] idx;
    set = '0;
    clr = '0;
    idx = isl_lowest(req);
    nxt_s = s_ff;
    nxt_s.isr_start = 1'b0;
    nxt_s.brst_clr = 1'b0;
    nxt_s.por_abort = 1'b0;
    nxt_s.stop_req = 1'b0;
    nxt_s.rdata = 8'h00;

    if (wr_i) begin
      case (addr_i)
        `ISL_ADDR_GIE: nxt_s.gie = wdata_i[6:0];
        `ISL_ADDR_EP_EN: nxt_s.ep_en = wdata_i[4:0];
        `ISL_ADDR_PSC: nxt_s.psc_brst = wdata_i[`ISL_PSC_BRST_BIT];
        `ISL_ADDR_DAC_EN: nxt_s.dac_en = wdata_i;
        `ISL_ADDR_DAC_POL: nxt_s.dac_pol = wdata_i;
        `ISL_ADDR_GPIO_CFG: nxt_s.gpio_cfg = wdata_i;
        `ISL_ADDR_HUB_EN: nxt_s.hub_en = wdata_i[3:0];
        `ISL_ADDR_HUB_FORCE: nxt_s.force_dn = wdata_i;
        `ISL_ADDR_I2C_SC: begin
          nxt_s.i2c = isl_i2c_ctl_t'(wdata_i[6:0]);
          if (s_ff.i2c.master && !wdata_i[`ISL_I2C_MASTER_BIT]) begin
            nxt_s.stop_req = 1'b1;
            nxt_s.i2c.xmit = 1'b0;
          end
        end
        default: ;
      endcase
      for (int p = 0; p < 4; p++) begin
        if (addr_i == 8'(`ISL_ADDR_GPIO_EN0 + p)) begin
          nxt_s.gpio_en[8*p +: 8] = wdata_i;
        end
      end
    end

    if (rd_i) begin
      case (addr_i)
        `ISL_ADDR_GIE: nxt_s.rdata = {1'b0, s_ff.gie};
        `ISL_ADDR_EP_EN: nxt_s.rdata = {3'h0, s_ff.ep_en};
        `ISL_ADDR_PSC: nxt_s.rdata = {s_ff.irq, 1'b0, s_ff.psc_brst, 5'h00};
        `ISL_ADDR_DAC_EN: nxt_s.rdata = s_ff.dac_en;
        `ISL_ADDR_DAC_POL: nxt_s.rdata = s_ff.dac_pol;
        `ISL_ADDR_GPIO_CFG: nxt_s.rdata = s_ff.gpio_cfg;
        `ISL_ADDR_HUB_EN: nxt_s.rdata = {4'h0, s_ff.hub_en};
        `ISL_ADDR_HUB_FORCE: nxt_s.rdata = s_ff.force_dn;
        `ISL_ADDR_I2C_SC: nxt_s.rdata = {1'b0, s_ff.i2c};
        `ISL_ADDR_PEND_LO: nxt_s.rdata = s_ff.pend[7:0];
        `ISL_ADDR_PEND_HI: nxt_s.rdata = {4'h0, s_ff.pend[11:8]};
        default: nxt_s.rdata = 8'h00;
      endcase
      for (int p = 0; p < 4; p++) begin
        if (addr_i == 8'(`ISL_ADDR_GPIO_EN0 + p)) begin
          nxt_s.rdata = s_ff.gpio_en[8*p +: 8];
        end
      end
    end

    // periodic timers
    if (s_ff.t128 == T128_CYC - 17'h00001) begin
      nxt_s.t128 = '0;
      set[`ISL_V_T128] = 1'b1;
    end else begin
      nxt_s.t128 = s_ff.t128 + 17'h00001;
    end
    if (s_ff.t1ms == T1MS_CYC - 17'h00001) begin
      nxt_s.t1ms = '0;
      set[`ISL_V_T1MS] = 1'b1;
    end else begin
      nxt_s.t1ms = s_ff.t1ms + 17'h00001;
    end

    // upstream bus reset
    if (se0) begin
      if (!s_ff.brst_det) begin
        if (s_ff.se0_cnt == 11'(`ISL_BRST_CYC - 1)) begin
          nxt_s.brst_det = 1'b1;
          nxt_s.psc_brst = 1'b1;
          nxt_s.brst_clr = 1'b1;
          nxt_s.hub_en = 4'h0;
          nxt_s.force_dn = 8'h00;
          nxt_s.por_abort = por_delay_i;
        end else begin
          nxt_s.se0_cnt = s_ff.se0_cnt + 11'h001;
        end
      end
    end else begin
      nxt_s.se0_cnt = '0;
      if (s_ff.brst_det) begin
        nxt_s.brst_det = 1'b0;
        set[`ISL_V_BRST] = 1'b1;
      end
    end

    set[`ISL_V_EP0 +: 5] = ep_in_ack_i | ep_out_ack_i;
    set[`ISL_V_HUB] = hub_raw;
    set[`ISL_V_DAC] = dac_trig;
    set[`ISL_V_GPIO] = parallel_assist_port_on ? parallel_assist_port_ev_i : gpio_trig;

    // I2C state machine conditions
    if (i2c_ev_i.arb_lost) begin
      nxt_s.i2c.master = 1'b0;
      nxt_s.i2c.arb_lost = 1'b1;
      nxt_s.arb_wait = 1'b1;
    end else if (i2c_ev_i.byte_done) begin
      nxt_s.i2c_first = 1'b0;
      set[`ISL_V_I2C] = 1'b1;
      if (s_ff.i2c.master) begin
        if (s_ff.i2c.xmit) begin
          nxt_s.i2c.proceed = 1'b0;
        end
      end else if (s_ff.i2c.xmit) begin
        nxt_s.i2c.ack = i2c_ev_i.ack_in;
        nxt_s.i2c.proceed = 1'b0;
      end else begin
        nxt_s.i2c.addr = s_ff.i2c_first;
        nxt_s.i2c.proceed = 1'b0;
      end
    end
    if (i2c_ev_i.start) begin
      nxt_s.i2c_first = 1'b1;
    end
    if (i2c_ev_i.stop) begin
      if (s_ff.arb_wait) begin
        nxt_s.arb_wait = 1'b0;
        set[`ISL_V_I2C] = 1'b1;
      end else if (!s_ff.i2c.master && !s_ff.i2c.xmit && s_ff.i2c.ack) begin
        nxt_s.i2c.stop_seen = 1'b1;
        nxt_s.i2c.proceed = 1'b0;
        set[`ISL_V_I2C] = 1'b1;
      end
    end

    // interrupt entry sequence
    case (s_ff.st)
      ISL_IDLE: begin
        if (cpu_instr_end_i && cpu_gie_i && req != '0) begin
          nxt_s.st = ISL_ENTRY;
          nxt_s.ent_cnt = 4'h0;
          nxt_s.vec = idx + 4'h1;
          clr[idx] = 1'b1;
        end
      end
      ISL_ENTRY: begin
        if (s_ff.ent_cnt == 4'(`ISL_ENTRY_CYC - 1)) begin
          nxt_s.isr_start = 1'b1;
          nxt_s.st = ISL_IDLE;
        end else begin
          nxt_s.ent_cnt = s_ff.ent_cnt + 4'h1;
        end
      end
      default: nxt_s.st = ISL_IDLE;
    endcase

    // new events win over the service clear
    nxt_s.pend = (s_ff.pend & ~clr) | set;
    nxt_s.irq = |(nxt_s.pend & isl_en_vec(nxt_s.gie, nxt_s.ep_en));
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rdata_o = s_ff.rdata;
  assign isr_start_o = s_ff.isr_start;
  assign vector_o = s_ff.vec;
  assign irq_o = s_ff.irq;
  assign brst_clr_o = s_ff.brst_clr;
  assign por_abort_o = s_ff.por_abort;
  assign hub_port_en_o = s_ff.hub_en;
  assign hub_force_o = s_ff.force_dn;
  assign i2c_ctl_o = s_ff.i2c;
  assign i2c_stop_req_o = s_ff.stop_req;

  AST_ENTRY_LATENCY: assert property ($rose(s_ff.st == ISL_ENTRY)
    |-> ##15 isr_start_o)
    else $error("service routine start not 15 cycles after entry");

  AST_BRST_DETECT: assert property ($rose(s_ff.brst_det)
    |-> s_ff.psc_brst && brst_clr_o && $past(se0, 1500))
    else $error("bus reset detect without status bit or long low");

  AST_BRST_CLEAR: assert property ($rose(s_ff.brst_det)
    |-> hub_port_en_o == 4'h0 && hub_force_o == 8'h00)
    else $error("hub port registers not cleared by bus reset");

  AST_BRST_IRQ: assert property (s_ff.brst_det && !se0
    |=> s_ff.pend[`ISL_V_BRST] && !s_ff.brst_det)
    else $error("bus reset interrupt missing at end of reset");

  AST_TIMER: assert property (s_ff.t128 == T128_CYC - 17'h00001
    |=> s_ff.pend[`ISL_V_T128] && s_ff.t128 == 17'h00000)
    else $error("128 us tick did not set its pending bit");

  AST_HUB_GATE: assert property (!hub_raw && !s_ff.pend[`ISL_V_HUB]
    |=> !s_ff.pend[`ISL_V_HUB])
    else $error("hub interrupt without an admitted event");

  AST_PARALLEL_ASSIST_PORT_OWNS: assert property (parallel_assist_port_on && !parallel_assist_port_ev_i
    && !s_ff.pend[`ISL_V_GPIO] |=> !s_ff.pend[`ISL_V_GPIO])
    else $error("GPIO vector raised while parallel port owns it");

  AST_I2C_PROCEED: assert property (i2c_ev_i.byte_done
    && !i2c_ev_i.arb_lost && !s_ff.i2c.master
    |=> !i2c_ctl_o.proceed && s_ff.pend[`ISL_V_I2C])
    else $error("slave byte irq without proceed cleared");

  AST_ARB_LOST: assert property (i2c_ev_i.arb_lost
    |=> !i2c_ctl_o.master && i2c_ctl_o.arb_lost && s_ff.arb_wait)
    else $error("arbitration loss not recorded");

  AST_STOP_REQ: assert property (wr_i && addr_i == `ISL_ADDR_I2C_SC
    && s_ff.i2c.master && !wdata_i[`ISL_I2C_MASTER_BIT] |=> i2c_stop_req_o)
    else $error("clearing master bit did not request a stop");

  AST_PRIORITY: assert property (s_ff.st == ISL_IDLE && cpu_instr_end_i
    && cpu_gie_i && req[`ISL_V_BRST] |=> vector_o == 4'h1)
    else $error("bus reset not taken first");

endmodule : isl_top

/* isl_cpu_model.sv */
`timescale 1ns/10ps
module isl_cpu_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  input wire logic isr_start_i,
  input wire logic fw_ei_i,
  input wire logic [3:0] instr_len_i,
  output logic instr_end_o,
  output logic gie_o,
  output logic [7:0] lat_o
);
  logic busy_ff;
  logic [3:0] cnt_ff;
  // cpu enable drops for the whole entry sequence
  assign gie_o = fw_ei_i & ~busy_ff;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      instr_end_o <= 1'b0;
      lat_o <= 8'h00;
    end else if (busy_ff) begin
      // counts call and jump cycles
      if (isr_start_i) begin
        busy_ff <= 1'b0;
      end else begin
        lat_o <= lat_o + 8'h01;
      end
    end else if (instr_end_o && irq_i && gie_o) begin
      busy_ff <= 1'b1;
      instr_end_o <= 1'b0;
      lat_o <= 8'h00;
    end else begin
      instr_end_o <= (cnt_ff == instr_len_i - 4'h1);
      cnt_ff <= (cnt_ff == instr_len_i - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
    end
  end
endmodule : isl_cpu_model

/* tb.sv */
`timescale 1ns/10ps
module tb import isl_pkg::*;;
  logic sys_clk, rst, wr_en, rd_en, dp, dm, por_delay, parallel_assist_port_ev, fw_ei;
  logic [7:0] addr, wdata, rdata, dac_pin, hub_force, lat;
  logic [4:0] ep_in_ack, ep_out_ack;
  logic [31:0] gpio_pin;
  logic [3:0] vector, hub_en, instr_len;
  logic instr_end, gie, isr_start, irq, brst_clr, por_abort, stop_req;
  isl_hub_ev_t hub_ev;
  isl_i2c_ev_t i2c_ev;
  isl_i2c_ctl_t i2c_ctl;
  int error_cnt, comparisons, cyc, n_clr, n_abort, n_stop;

  isl_top #(.T128_CYC(17'h00028), .T1MS_CYC(17'h00064)) DUT (
    .sys_clk_i(sys_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_en), .rd_i(rd_en), .rdata_o(rdata), .dp_i(dp), .dm_i(dm),
    .por_delay_i(por_delay), .ep_in_ack_i(ep_in_ack),
    .ep_out_ack_i(ep_out_ack), .hub_ev_i(hub_ev), .dac_pin_i(dac_pin),
    .gpio_pin_i(gpio_pin), .parallel_assist_port_ev_i(parallel_assist_port_ev), .i2c_ev_i(i2c_ev),
    .cpu_instr_end_i(instr_end), .cpu_gie_i(gie), .isr_start_o(isr_start),
    .vector_o(vector), .irq_o(irq), .brst_clr_o(brst_clr),
    .por_abort_o(por_abort), .hub_port_en_o(hub_en),
    .hub_force_o(hub_force), .i2c_ctl_o(i2c_ctl), .i2c_stop_req_o(stop_req)
  );

  isl_cpu_model cpu (
    .sys_clk_i(sys_clk), .rst_i(rst), .irq_i(irq), .isr_start_i(isr_start),
    .fw_ei_i(fw_ei), .instr_len_i(instr_len), .instr_end_o(instr_end),
    .gie_o(gie), .lat_o(lat)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (brst_clr === 1'b1) n_clr <= n_clr + 1;
    if (por_abort === 1'b1) n_abort <= n_abort + 1;
    if (stop_req === 1'b1) n_stop <= n_stop + 1;
  end

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  task automatic chk_reg(string nm, logic [7:0] a, logic [7:0] m,
                         logic [7:0] e);
    logic [7:0] d;
    repeat (3) @(posedge sys_clk);
    reg_rd(a, d);
    chk(nm, {8'h00, d & m}, {8'h00, e});
  endtask : chk_reg

  task automatic svc(input logic [3:0] v);
    @(posedge sys_clk);
    fw_ei <= 1'b1;
    repeat (200) begin
      @(posedge sys_clk);
      if (isr_start === 1'b1) break;
    end
    fw_ei <= 1'b0;
    chk("isr_start", {15'h0000, isr_start}, 16'h0001);
    chk("vector", {12'h000, vector}, {12'h000, v});
    chk("latency", {8'h00, lat}, 16'h000F);
  endtask : svc

  task automatic s_reg();
    chk_reg("gie_rst", 8'h20, 8'hFF, 8'h00);
    chk_reg("irq_idle", 8'h30, 8'h80, 8'h00);
    reg_wr(8'h20, 8'hFF);
    chk_reg("gie", 8'h20, 8'hFF, 8'h7F);
    chk_reg("unmapped", 8'h7E, 8'hFF, 8'h00);
    reg_wr(8'h20, 8'h00);
  endtask : s_reg

  task automatic s_brst();
    reg_wr(8'h49, 8'h0F);
    reg_wr(8'h51, 8'hFF);
    @(posedge sys_clk) ep_in_ack <= 5'h01;
    ep_out_ack <= 5'h02;
    @(posedge sys_clk) ep_in_ack <= 5'h00;
    ep_out_ack <= 5'h00;
    @(posedge sys_clk) {dp, dm, por_delay} <= 3'b001;
    repeat (2010) @(posedge sys_clk);
    chk("port_en", {12'h000, hub_en}, 16'h0000);
    chk("force", {8'h00, hub_force}, 16'h0000);
    chk("clr", 16'(n_clr), 16'h0001);
    chk("abort", 16'(n_abort), 16'h0001);
    chk_reg("psc", 8'h30, 8'h20, 8'h20);
    chk_reg("brst_pend", 8'h39, 8'h01, 8'h00);
    @(posedge sys_clk) {dp, por_delay} <= 2'b10;
    chk_reg("pend", 8'h39, 8'h19, 8'h19);
    reg_wr(8'h20, 8'h01);
    reg_wr(8'h21, 8'h03);
    chk_reg("irq_sense", 8'h30, 8'h80, 8'h80);
    svc(4'h1);
    svc(4'h4);
    svc(4'h5);
    chk_reg("pend_clr", 8'h39, 8'h19, 8'h00);
    reg_wr(8'h20, 8'h00);
  endtask : s_brst

  task automatic s_timer(logic [7:0] en, logic [3:0] v, logic [15:0] p);
    int t0;
    reg_wr(8'h20, en);
    repeat (3) svc(v);
    t0 = cyc;
    svc(v);
    chk("period", 16'(cyc - t0), p);
    reg_wr(8'h20, 8'h00);
  endtask : s_timer

  task automatic hub_pulse(logic [11:0] e, logic exp);
    @(posedge sys_clk) hub_ev <= e;
    @(posedge sys_clk) hub_ev <= 12'h000;
    chk_reg("hub_pend", 8'h3A, 8'h01, {7'h00, exp});
    if (exp) svc(4'h9);
  endtask : hub_pulse

  task automatic s_hub();
    reg_wr(8'h49, 8'h01);
    reg_wr(8'h51, 8'h0C);
    reg_wr(8'h20, 8'h08);
    chk("force", {8'h00, hub_force}, 16'h000C);
    hub_pulse(12'h220, 1'b0);
    hub_pulse(12'h001, 1'b1);
    hub_pulse(12'h100, 1'b1);
    hub_pulse(12'h010, 1'b1);
  endtask : s_hub

  task automatic s_dac();
    reg_wr(8'h31, 8'h03);
    reg_wr(8'h32, 8'h01);
    reg_wr(8'h20, 8'h10);
    @(posedge sys_clk) dac_pin <= 8'h03;
    chk_reg("dac_pend", 8'h3A, 8'h02, 8'h02);
    svc(4'hA);
    @(posedge sys_clk) dac_pin <= 8'h01;
    chk_reg("dac_lock", 8'h3A, 8'h02, 8'h00);
    chk_reg("dac_en", 8'h31, 8'hFF, 8'h03);
    @(posedge sys_clk) dac_pin <= 8'h00;
    @(posedge sys_clk) dac_pin <= 8'h02;
    @(posedge sys_clk) dac_pin <= 8'h00;
    chk_reg("dac_pend", 8'h3A, 8'h02, 8'h02);
    svc(4'hA);
  endtask : s_dac

  task automatic s_gpio();
    reg_wr(8'h33, 8'h02);
    reg_wr(8'h34, 8'h01);
    reg_wr(8'h35, 8'h01);
    reg_wr(8'h20, 8'h20);
    @(posedge sys_clk) gpio_pin <= 32'h000001FF;
    chk_reg("gpio_pend", 8'h3A, 8'h04, 8'h04);
    svc(4'hB);
    @(posedge sys_clk) gpio_pin <= 32'h000001FE;
    chk_reg("gpio_lock", 8'h3A, 8'h04, 8'h00);
    chk_reg("gpio_en", 8'h35, 8'hFF, 8'h01);
    @(posedge sys_clk) gpio_pin <= 32'h000000FF;
    reg_wr(8'h33, 8'h82);
    @(posedge sys_clk) gpio_pin <= 32'h000000FE;
    chk_reg("par_block", 8'h3A, 8'h04, 8'h00);
    reg_wr(8'h35, 8'h00);
    @(posedge sys_clk) parallel_assist_port_ev <= 1'b1;
    @(posedge sys_clk) parallel_assist_port_ev <= 1'b0;
    chk_reg("par_pend", 8'h3A, 8'h04, 8'h04);
    svc(4'hB);
    reg_wr(8'h33, 8'h00);
  endtask : s_gpio

  task automatic i2c(logic [7:0] w, logic [4:0] e1, logic [4:0] e2,
                     logic [6:0] exp, logic irq_exp);
    if (w != 8'hFF) reg_wr(8'h38, w);
    @(posedge sys_clk) i2c_ev <= e1;
    @(posedge sys_clk) i2c_ev <= e2;
    @(posedge sys_clk) i2c_ev <= 5'h00;
    @(posedge sys_clk);
    chk("i2c_ctl", {9'h000, i2c_ctl}, {9'h000, exp});
    if (irq_exp) svc(4'hC);
    else chk_reg("i2c_pend", 8'h3A, 8'h08, 8'h00);
  endtask : i2c

  task automatic s_i2c();
    reg_wr(8'h20, 8'h40);
    i2c(8'h41, 5'h08, 5'h11, 7'h03, 1'b1);
    i2c(8'h41, 5'h11, 5'h00, 7'h01, 1'b1);
    i2c(8'h41, 5'h04, 5'h00, 7'h11, 1'b1);
    i2c(8'h40, 5'h04, 5'h00, 7'h40, 1'b0);
    i2c(8'h44, 5'h11, 5'h00, 7'h05, 1'b1);
    i2c(8'h45, 5'h10, 5'h00, 7'h04, 1'b1);
    i2c(8'h4C, 5'h11, 5'h00, 7'h0C, 1'b1);
    i2c(8'h48, 5'h10, 5'h00, 7'h48, 1'b1);
    reg_wr(8'h38, 8'h40);
    repeat (2) @(posedge sys_clk);
    chk("stop_req", 16'(n_stop), 16'h0001);
    i2c(8'h48, 5'h02, 5'h00, 7'h60, 1'b0);
    i2c(8'hFF, 5'h04, 5'h00, 7'h60, 1'b1);
  endtask : s_i2c

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {rst, wr_en, rd_en, dp, dm, por_delay, parallel_assist_port_ev, fw_ei} = 8'h90;
    {addr, wdata, dac_pin} = 24'h000002;
    {ep_in_ack, ep_out_ack, hub_ev, i2c_ev} = 27'h0000000;
    gpio_pin = 32'h000000FF;
    instr_len = 4'h4;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    s_reg();
    s_brst();
    s_hub();
    s_dac();
    s_gpio();
    s_i2c();
    instr_len <= 4'h1;
    s_timer(8'h02, 4'h2, 16'h0028);
    s_timer(8'h04, 4'h3, 16'h0064);
    give_verdict();
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end
endmodule : tb
